// >>> design/lcs_regs.svh
// Constants of the column driver command slave and its bus master.
`ifndef LCS_REGS_SVH
`define LCS_REGS_SVH

// Slave address: fixed upper six bits, lowest bit from a strap pin.
`define LCS_SLAVE_ADDR_HI   6'h1e
// Last valid column pointer value.
`define LCS_COL_LAST        6'h27
// RAM access nibbles from this value upward are start-bank commands.
`define LCS_BANK_NIB_MIN    4'hc
// Mode and access command field positions.
`define LCS_MODE_MUX_LSB    3
`define LCS_MODE_STAT_LSB   1
`define LCS_MODE_TYPE_BIT   0
`define LCS_ACC_ORDER_LSB   2
// Reset values; blank display after power-on.
`define LCS_MUX_RST         2'h0
`define LCS_STATUS_RST      2'h0
`define LCS_TYPE_RST        1'h0
`define LCS_BANK_RST        2'h0
`define LCS_ORDER_RST       2'h0
`define LCS_COL_RST         6'h00
`define LCS_SUB_RST         4'h0
// Master register map, byte addresses.
`define LCS_REG_CMD         4'h0
`define LCS_REG_STAT        4'h4
// Command register fields.
`define LCS_CMD_OP_LSB      0
`define LCS_CMD_NACK_BIT    2
`define LCS_CMD_TX_LSB      8
// Status register fields.
`define LCS_STAT_BUSY_BIT   0
`define LCS_STAT_ACK_BIT    1
`define LCS_STAT_RX_LSB     8
// Timing: clock period and fastest serial clock period, in ns.
`define LCS_CLK_PERIOD_NS   4
`define LCS_SCL_PERIOD_NS   10000
`define LCS_QTR_CYC \
   (((`LCS_SCL_PERIOD_NS / 4) + `LCS_CLK_PERIOD_NS - 1) / `LCS_CLK_PERIOD_NS)

`endif

// >>> design/lcs_pkg.sv
// Types shared by the column driver command slave and its bus master.
package lcs_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RX   = 3'b001,
      ST_ACK  = 3'b010,
      ST_TX   = 3'b011,
      ST_TACK = 3'b100
   } lcs_dev_state_t;

   typedef enum logic [2:0] {
      CMD_XADDR  = 3'b000,
      CMD_MODE   = 3'b001,
      CMD_DEVSEL = 3'b010,
      CMD_ACCESS = 3'b011,
      CMD_BANK   = 3'b100
   } lcs_cmd_t;

   typedef enum logic [1:0] {
      OP_START = 2'b00,
      OP_STOP  = 2'b01,
      OP_WRITE = 2'b10,
      OP_READ  = 2'b11
   } lcs_op_t;

endpackage : lcs_pkg

// >>> design/lcs_if.sv
// Two-wire link between the bus master and the column driver slave.
`timescale 1ns/1ns
interface lcs_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl;
   logic sda;

   // Open-drain wires with pull-ups: any enabled low driver wins.
   assign scl = ~(host_scl_oe & ~host_scl_o);
   assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

   modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
                 input scl, sda);
   modport dev  (output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface : lcs_if

// >>> design/lcs_line_mon.sv
// Start, stop and clock edge detector for the two-wire link.
`timescale 1ns/1ns
module lcs_line_mon (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // Line levels
   input  wire logic scl_i,
   input  wire logic sda_i,
   // Events
   output logic      start_o,
   output logic      stop_o,
   output logic      rise_o,
   output logic      fall_o
);
   logic scl_q;
   logic sda_q;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_i;
         sda_q <= sda_i;
      end
   end

   assign start_o = scl_q & scl_i & sda_q & ~sda_i;
   assign stop_o  = scl_q & scl_i & ~sda_q & sda_i;
   assign rise_o  = ~scl_q & scl_i;
   assign fall_o  = scl_q & ~scl_i;
endmodule : lcs_line_mon

// >>> design/lcs_dev.sv
// Column driver serial slave: address match, command decode, data stream.
//
// Summary of operation
// - Answer address 011110 plus strap bit.
// - Matching devices ack; others ignore until start.
// - Write: first byte after address is an acked command.
// - Command top bit set means another command.
// - Data acked only by subaddress-matching device.
// - Read: after address ack, shift RAM bytes out.
// - Master nack ends read; release data line.
// - Written and master-acked read bytes advance pointer; its wrap advances subaddress.
// - Never decode commands during a read.
// - Opcode 10 below flag sets mode fields.
// - Mux field picks 8/16/24/32 rows.
// - Status field: blank, normal, all on, inverse.
// - System type bit picks row-driver configuration.
// - Opcode 11111 sets start bank 0 to 3.
// - Opcode 110 loads subaddress counter 0 to 15.
// - Opcode 111, nibble under 12: access order.
// - Access command low bits pick RAM bank.
// - Opcode 0 loads six-bit column pointer.
// - Start and stop are sda edges, scl high.
// - Data changes only while scl low.
// - Ninth clock carries acknowledge, pulled low.
// - Store or return only on subaddress match.
// - Subaddress counter wraps past 15 to 0.
`timescale 1ns/1ns
`include "lcs_regs.svh"
module lcs_dev import lcs_pkg::*; (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Link
   lcs_if.dev              bus,
   // Straps
   input  wire logic       address_lsb_pin_i,
   input  wire logic [3:0] hardware_subaddress_pins_i,
   // Display RAM side
   input  wire logic [7:0] ram_rd_data_i,
   output logic      [7:0] ram_wr_data_o,
   output logic            ram_wr_o,
   output logic            ram_rd_o,
   output logic      [5:0] column_pointer_o,
   output logic      [1:0] ram_bank_o,
   output logic      [3:0] subaddress_o,
   // Display settings
   output logic      [1:0] mux_rate_o,
   output logic      [1:0] display_status_o,
   output logic            system_type_o,
   output logic      [1:0] top_bank_o,
   output logic      [1:0] access_order_o
);

   function automatic lcs_cmd_t cmd_kind(input logic [7:0] b);
      lcs_cmd_t k;
      if (!b[6])
         k = CMD_XADDR;
      else if (!b[5])
         k = CMD_MODE;
      else if (!b[4])
         k = CMD_DEVSEL;
      else if (b[3:0] >= `LCS_BANK_NIB_MIN)
         k = CMD_BANK;
      else
         k = CMD_ACCESS;
      return k;
   endfunction : cmd_kind

   ////////////////////////////////////////////////////////////////////////
   lcs_dev_state_t state_q;
   logic [7:0]     shreg_q;
   logic [3:0]     cnt_q;
   logic           addr_phase_q;
   logic           cmd_q;
   logic           rw_q;
   logic           adv_pend_q;
   logic           mack_q;
   logic           sda_oe_q;
   logic           start;
   logic           stop;
   logic           rise;
   logic           fall;
   logic           byte_done;
   logic           addr_match;
   logic           sub_match;
   logic           cmd_ev;
   logic           data_ev;
   logic           adv_ev;

   lcs_line_mon u_mon (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .scl_i   (bus.scl),
      .sda_i   (bus.sda),
      .start_o (start),
      .stop_o  (stop),
      .rise_o  (rise),
      .fall_o  (fall)
   );

   assign byte_done  = fall && (state_q == ST_RX) && (cnt_q == 4'h8);
   assign addr_match = (shreg_q[7:1] ==
                        {`LCS_SLAVE_ADDR_HI, address_lsb_pin_i});
   assign sub_match  = (subaddress_o == hardware_subaddress_pins_i);
   assign cmd_ev     = byte_done && !addr_phase_q && cmd_q && !rw_q;
   assign data_ev    = byte_done && !addr_phase_q && !cmd_q && !rw_q;
   assign adv_ev     = (fall && (state_q == ST_ACK) && adv_pend_q) ||
                       (rise && (state_q == ST_TACK) && !bus.sda);

   assign bus.dev_sda_o  = 1'b0;
   assign bus.dev_sda_oe = sda_oe_q;

   ////////////////////////////////////////////////////////////////////////
   // Protocol engine. The link lines are sampled by the system clock, so
   // the serial clock must stay far slower than it.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state_q      <= ST_IDLE;
         shreg_q      <= 8'h00;
         cnt_q        <= 4'h0;
         addr_phase_q <= 1'b0;
         cmd_q        <= 1'b0;
         rw_q         <= 1'b0;
         adv_pend_q   <= 1'b0;
         mack_q       <= 1'b0;
         sda_oe_q     <= 1'b0;
         ram_rd_o     <= 1'b0;
      end else begin
         ram_rd_o <= 1'b0;
         if (start) begin
            state_q      <= ST_RX;
            cnt_q        <= 4'h0;
            addr_phase_q <= 1'b1;
            cmd_q        <= 1'b1;
            rw_q         <= 1'b0;
            adv_pend_q   <= 1'b0;
            sda_oe_q     <= 1'b0;
         end else if (stop) begin
            state_q  <= ST_IDLE;
            sda_oe_q <= 1'b0;
         end else begin
            case (state_q)
               ST_RX: begin
                  if (rise) begin
                     shreg_q <= {shreg_q[6:0], bus.sda};
                     cnt_q   <= cnt_q + 4'h1;
                  end else if (byte_done) begin
                     addr_phase_q <= 1'b0;
                     adv_pend_q   <= data_ev;
                     state_q      <= ST_ACK;
                     if (addr_phase_q) begin
                        if (addr_match) begin
                           sda_oe_q <= 1'b1;
                           rw_q     <= shreg_q[0];
                        end else begin
                           state_q <= ST_IDLE;
                        end
                     end else if (cmd_q) begin
                        sda_oe_q <= 1'b1;
                        cmd_q    <= shreg_q[7];
                     end else begin
                        sda_oe_q <= sub_match;
                     end
                  end
               end
               ST_ACK: begin
                  if (fall) begin
                     cnt_q <= 4'h0;
                     if (rw_q) begin
                        state_q  <= ST_TX;
                        shreg_q  <= ram_rd_data_i;
                        ram_rd_o <= sub_match;
                        sda_oe_q <= sub_match & ~ram_rd_data_i[7];
                     end else begin
                        state_q  <= ST_RX;
                        sda_oe_q <= 1'b0;
                     end
                  end
               end
               ST_TX: begin
                  if (fall) begin
                     cnt_q <= cnt_q + 4'h1;
                     if (cnt_q == 4'h7) begin
                        state_q  <= ST_TACK;
                        sda_oe_q <= 1'b0;
                     end else begin
                        shreg_q  <= {shreg_q[6:0], 1'b1};
                        sda_oe_q <= sub_match & ~shreg_q[6];
                     end
                  end
               end
               ST_TACK: begin
                  if (rise) begin
                     mack_q <= ~bus.sda;
                  end else if (fall) begin
                     cnt_q <= 4'h0;
                     if (mack_q) begin
                        state_q  <= ST_TX;
                        shreg_q  <= ram_rd_data_i;
                        ram_rd_o <= sub_match;
                        sda_oe_q <= sub_match & ~ram_rd_data_i[7];
                     end else begin
                        state_q  <= ST_IDLE;
                        sda_oe_q <= 1'b0;
                     end
                  end
               end
               default: begin
                  sda_oe_q <= 1'b0;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Display RAM write port.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ram_wr_o      <= 1'b0;
         ram_wr_data_o <= 8'h00;
      end else begin
         ram_wr_o <= data_ev && sub_match;
         if (data_ev) begin
            ram_wr_data_o <= shreg_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command decoding and data pointer.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         mux_rate_o       <= `LCS_MUX_RST;
         display_status_o <= `LCS_STATUS_RST;
         system_type_o    <= `LCS_TYPE_RST;
         top_bank_o       <= `LCS_BANK_RST;
         access_order_o   <= `LCS_ORDER_RST;
         ram_bank_o       <= `LCS_BANK_RST;
         column_pointer_o <= `LCS_COL_RST;
         subaddress_o     <= `LCS_SUB_RST;
      end else if (cmd_ev) begin
         case (cmd_kind(shreg_q))
            CMD_XADDR: begin
               column_pointer_o <= shreg_q[5:0];
            end
            CMD_MODE: begin
               mux_rate_o       <= shreg_q[`LCS_MODE_MUX_LSB +: 2];
               display_status_o <= shreg_q[`LCS_MODE_STAT_LSB +: 2];
               system_type_o    <= shreg_q[`LCS_MODE_TYPE_BIT];
            end
            CMD_DEVSEL: begin
               subaddress_o <= shreg_q[3:0];
            end
            CMD_BANK: begin
               top_bank_o <= shreg_q[1:0];
            end
            default: begin
               access_order_o <= shreg_q[`LCS_ACC_ORDER_LSB +: 2];
               ram_bank_o     <= shreg_q[1:0];
            end
         endcase
      end else if (adv_ev) begin
         if (column_pointer_o >= `LCS_COL_LAST) begin
            column_pointer_o <= `LCS_COL_RST;
            subaddress_o     <= subaddress_o + 4'h1;
         end else begin
            column_pointer_o <= column_pointer_o + 6'h01;
         end
      end
   end
endmodule : lcs_dev

// >>> design/lcs_host.sv
// Serial bus master for the column driver, ordered over Avalon-MM.
`timescale 1ns/1ns
`include "lcs_regs.svh"
module lcs_host import lcs_pkg::*; (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   // Link
   lcs_if.host              bus
);
   localparam logic [9:0] QTR_LAST = 10'(`LCS_QTR_CYC - 1);

   logic [9:0] div_q;
   logic       tick;
   lcs_op_t    op_q;
   logic       busy_q;
   logic [1:0] qtr_q;
   logic [3:0] bit_q;
   logic [7:0] tx_q;
   logic [7:0] rx_q;
   logic       nack_q;
   logic       ack_q;
   logic       scl_oe_q;
   logic       sda_oe_q;
   logic       cmd_go;
   logic       busy_block;

   assign tick       = (div_q == QTR_LAST);
   assign busy_block = avs_write_i && (avs_address_i == `LCS_REG_CMD) &&
                       busy_q;
   assign cmd_go     = avs_write_i && !avs_waitrequest_o &&
                       (avs_address_i == `LCS_REG_CMD);

   assign bus.host_scl_o  = 1'b0;
   assign bus.host_sda_o  = 1'b0;
   assign bus.host_scl_oe = scl_oe_q;
   assign bus.host_sda_oe = sda_oe_q;

   ////////////////////////////////////////////////////////////////////////
   // Quarter-bit enable divider.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || tick) begin
         div_q <= 10'h000;
      end else begin
         div_q <= div_q + 10'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register slave; a command write waits while a transfer is running.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= 32'h0000_0000;
      end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o &&
                   !busy_block) begin
         avs_waitrequest_o <= 1'b0;
         if (avs_read_i && (avs_address_i == `LCS_REG_STAT)) begin
            avs_readdata_o <= {16'h0000, rx_q, 6'h00, ack_q, busy_q};
         end else begin
            avs_readdata_o <= 32'h0000_0000;
         end
      end else begin
         avs_waitrequest_o <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bit engine. No clock stretching: the slave never holds the clock.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         op_q     <= OP_STOP;
         busy_q   <= 1'b0;
         qtr_q    <= 2'h0;
         bit_q    <= 4'h0;
         tx_q     <= 8'h00;
         rx_q     <= 8'h00;
         nack_q   <= 1'b0;
         ack_q    <= 1'b0;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else if (cmd_go) begin
         op_q   <= lcs_op_t'(avs_writedata_i[`LCS_CMD_OP_LSB +: 2]);
         tx_q   <= avs_writedata_i[`LCS_CMD_TX_LSB +: 8];
         nack_q <= avs_writedata_i[`LCS_CMD_NACK_BIT];
         busy_q <= 1'b1;
         qtr_q  <= 2'h0;
         bit_q  <= 4'h0;
      end else if (busy_q && tick) begin
         qtr_q <= qtr_q + 2'h1;
         case (op_q)
            OP_START: begin
               case (qtr_q)
                  2'h0: sda_oe_q <= 1'b0;
                  2'h1: scl_oe_q <= 1'b0;
                  2'h2: sda_oe_q <= 1'b1;
                  default: begin
                     scl_oe_q <= 1'b1;
                     busy_q   <= 1'b0;
                  end
               endcase
            end
            OP_STOP: begin
               case (qtr_q)
                  2'h0: sda_oe_q <= 1'b1;
                  2'h1: scl_oe_q <= 1'b0;
                  2'h2: sda_oe_q <= 1'b0;
                  default: busy_q <= 1'b0;
               endcase
            end
            default: begin
               case (qtr_q)
                  2'h0: begin
                     if (bit_q == 4'h8) begin
                        sda_oe_q <= (op_q == OP_READ) && !nack_q;
                     end else begin
                        sda_oe_q <= (op_q == OP_WRITE) && !tx_q[7];
                     end
                  end
                  2'h1: scl_oe_q <= 1'b0;
                  2'h2: begin
                     if (bit_q == 4'h8) begin
                        ack_q <= !bus.sda;
                     end else begin
                        rx_q <= {rx_q[6:0], bus.sda};
                     end
                  end
                  default: begin
                     scl_oe_q <= 1'b1;
                     tx_q     <= {tx_q[6:0], 1'b1};
                     bit_q    <= bit_q + 4'h1;
                     if (bit_q == 4'h8) begin
                        sda_oe_q <= 1'b0;
                        busy_q   <= 1'b0;
                     end
                  end
               endcase
            end
         endcase
      end
   end
endmodule : lcs_host

// >>> test/lcs_link_checker.sv
// Assertions on the two-wire link between master and column slave.
`timescale 1ns/1ns
`include "lcs_regs.svh"
module lcs_link_checker (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Link lines
   input wire logic host_scl_o,
   input wire logic host_scl_oe,
   input wire logic host_sda_o,
   input wire logic host_sda_oe,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   localparam int QTR = `LCS_QTR_CYC;
   logic [15:0] hi_cnt_q;
   logic [15:0] lo_cnt_q;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   // Phase lengths saturate so a long idle bus never wraps to a short one.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || !scl) begin
         hi_cnt_q <= 16'h0000;
      end else if (hi_cnt_q != 16'hffff) begin
         hi_cnt_q <= hi_cnt_q + 16'h0001;
      end
   end
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || scl) begin
         lo_cnt_q <= 16'h0000;
      end else if (lo_cnt_q != 16'hffff) begin
         lo_cnt_q <= lo_cnt_q + 16'h0001;
      end
   end

///////////////////////////////////////////////////////////////////////////////
   sequence s_start;
      $fell(sda) && scl;
   endsequence
   sequence s_stop;
      $rose(sda) && scl;
   endsequence
   sequence s_ack_clk;
      dev_sda_oe && $rose(scl);
   endsequence

   AST_DEV_SDA_AFTER_FALL: assert property (
      $changed(dev_sda_oe) |-> !scl && lo_cnt_q inside {[16'h0001:16'h0006]})
      else $error("device moved the data line outside the low phase");
   AST_OPEN_DRAIN: assert property (
      !host_scl_o && !host_sda_o && !dev_sda_o)
      else $error("a link driver offered a high level");
   AST_IDLE_AFTER_RESET: assert property (
      $rose(rst_n_i) |-> scl && sda && !dev_sda_oe)
      else $error("link not idle after reset");
   AST_START_SETUP: assert property (
      s_start |-> hi_cnt_q >= QTR)
      else $error("start came too soon after the clock rose");
   AST_START_HOLDS_SCL: assert property (
      s_start |-> scl [*8])
      else $error("clock line dropped right after a start");
   AST_STOP_FREES_BUS: assert property (
      s_stop |=> (scl && sda && !dev_sda_oe) [*8])
      else $error("bus not free after a stop");
   AST_ACK_STABLE_LOW: assert property (
      s_ack_clk |-> (dev_sda_oe && !sda) [*8])
      else $error("acknowledge not stable low while clock high");
   AST_SCL_HIGH_TIME: assert property (
      $fell(scl) |-> hi_cnt_q >= QTR)
      else $error("clock high phase too short");
   AST_SCL_LOW_TIME: assert property (
      $rose(scl) |-> lo_cnt_q >= QTR)
      else $error("clock low phase too short");

   cover property (s_ack_clk);
   cover property (s_stop);
endmodule : lcs_link_checker

// >>> test/lcd_column_i2c_command_slave_tb_top.sv
// Bench joining the master and the column slave over the link.
`timescale 1ns/1ns
`include "lcs_regs.svh"
module lcd_column_i2c_command_slave_tb_top;
   import lcs_pkg::*;
   localparam int LIMIT = 99000;
   typedef struct packed {
      logic [7:0] tx;
      logic       ack;
   } lcs_row_t;
   logic        clk_i;
   logic        rst_n_i;
   logic [3:0]  avs_address_i;
   logic        avs_read_i;
   logic        avs_write_i;
   logic [31:0] avs_writedata_i;
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   logic [7:0]  wr_data;
   logic        ram_wr;
   logic [5:0]  col;
   logic [3:0]  sub;
   logic [1:0]  mux;
   logic [1:0]  stat;
   logic [1:0]  top;
   logic [1:0]  order;
   logic        sys_type;
   logic [31:0] st;
   logic        sa_pin;
   logic        ram_rd;
   logic [1:0]  bank;
   lcs_row_t    rows [4];
   int          n_mismatch = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   int          wr_pulses = 0;
   int          rd_pulses = 0;

   lcs_if bus_if ();
   lcs_host lcs_host_i (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .bus(bus_if.host));
   lcs_dev lcs_dev_i (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus_if.dev),
      .address_lsb_pin_i(sa_pin), .hardware_subaddress_pins_i(4'h0),
      .ram_rd_data_i(8'h3c), .ram_wr_data_o(wr_data), .ram_wr_o(ram_wr),
      .ram_rd_o(ram_rd), .column_pointer_o(col), .ram_bank_o(bank),
      .subaddress_o(sub), .mux_rate_o(mux), .display_status_o(stat),
      .system_type_o(sys_type), .top_bank_o(top), .access_order_o(order));
   lcs_link_checker lcs_link_checker_i (
      .clk_i(clk_i), .rst_n_i(rst_n_i),
      .host_scl_o(bus_if.host_scl_o), .host_scl_oe(bus_if.host_scl_oe),
      .host_sda_o(bus_if.host_sda_o), .host_sda_oe(bus_if.host_sda_oe),
      .dev_sda_o(bus_if.dev_sda_o), .dev_sda_oe(bus_if.dev_sda_oe),
      .scl(bus_if.scl), .sda(bus_if.sda));

///////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : test_done

   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
         n_mismatch++;
      end
   endtask : chk

   // The request holds until waitrequest is seen low at a rising edge.
   task automatic av(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
      @(posedge clk_i);
      avs_write_i     <= wr;
      avs_read_i      <= ~wr;
      avs_address_i   <= a;
      avs_writedata_i <= d;
      do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
      st = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i  <= 1'b0;
   endtask : av

   task automatic link(input lcs_op_t op, input logic [7:0] b);
      av(1'b1, `LCS_REG_CMD, {16'h0000, b, 6'h00, op});
      do av(1'b0, `LCS_REG_STAT, 32'h0);
      while (st[`LCS_STAT_BUSY_BIT] !== 1'b0);
   endtask : link

///////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   // The timeout stands in for every unbounded wait on the master.
   always @(posedge clk_i) begin
      cycles++;
      if (ram_wr === 1'b1) wr_pulses++;
      if (ram_rd === 1'b1) rd_pulses++;
      if (cycles == LIMIT) begin
         n_mismatch++;
         test_done();
      end
   end

   initial begin
      rst_n_i         = 1'b0;
      avs_address_i   = 4'h0;
      avs_read_i      = 1'b0;
      avs_write_i     = 1'b0;
      avs_writedata_i = 32'h0;
      sa_pin          = 1'b1;
      rows = '{'{8'h7a, 1'b1},   // slave address
               '{8'hd6, 1'b1},   // mode, chained
               '{8'h27, 1'b1},   // last column, final command
               '{8'ha5, 1'b1}};  // data for device zero
      repeat (12) @(posedge clk_i);
      chk("idle lines", 32'h3, {30'h0, bus_if.scl, bus_if.sda});
      chk("waitrequest", 32'h1, {31'h0, avs_waitrequest_o});
      rst_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk("settings", 32'h0,
          {11'h0, bank, mux, stat, sys_type, top, order, col, sub});
      link(OP_START, 8'h00);
      foreach (rows[i]) begin
         link(OP_WRITE, rows[i].tx);
         chk("ack", {31'h0, rows[i].ack}, {31'h0, st[`LCS_STAT_ACK_BIT]});
      end
      link(OP_STOP, 8'h00);
      chk("mode", 32'h16, {27'h0, mux, stat, sys_type});
      chk("column", 32'h0, {26'h0, col});
      chk("subaddress", 32'h1, {28'h0, sub});
      chk("write data", 32'ha5, {24'h0, wr_data});
      chk("write pulses", 32'h1, wr_pulses);
      chk("read pulses", 32'h0, rd_pulses);
      chk("bus free", 32'h3, {30'h0, bus_if.scl, bus_if.sda});
      av(1'b0, 4'h8, 32'h0);
      chk("unmapped read", 32'h0, st);
      test_done();
   end
endmodule : lcd_column_i2c_command_slave_tb_top
